//--- design/status_defines.svh
/*
 Bit positions, masks, reset values and error-code bounds of the status block.
 Assumes inclusion by bare name from the status design files.
*/
`ifndef STATUS_DEFINES_SVH
`define STATUS_DEFINES_SVH

// Standard event latch bit positions
`define EVT_OPC_BIT 0
`define EVT_QUERY_BIT 2
`define EVT_DEVICE_BIT 3
`define EVT_EXEC_BIT 4
`define EVT_CMD_BIT 5
`define EVT_USER_BIT 6
`define EVT_POWER_BIT 7
`define EVT_USED_MASK 8'hFD
`define EVT_RESET_VALUE 8'h80
`define EVT_MASK_RESET 8'h00

// Operation condition bit positions
`define OPER_CAL_BIT 0
`define OPER_TEST_BIT 1
`define OPER_SETUP_BIT 2
`define OPER_TRIG_BIT 3
`define OPER_USED_MASK 16'h000F

// Questionable condition bit positions
`define QUES_OVERLOAD_BIT 3
`define QUES_TEMP_BIT 4
`define QUES_CLIP_BIT 5
`define QUES_NOCAL_BIT 8
`define QUES_LIMIT_BIT 9
`define QUES_MASKTEST_BIT 12
`define QUES_USED_MASK 16'h1338

// Status byte summary positions
`define STB_QUES_BIT 3
`define STB_ESB_BIT 5
`define STB_OPER_BIT 7

// Error-number windows, two's complement; the high bound is the fallback code
`define ERR_CMD_HI 16'hFF9C
`define ERR_CMD_LO 16'hFF39
`define ERR_EXEC_HI 16'hFF38
`define ERR_EXEC_LO 16'hFED5
`define ERR_DEV_HI 16'hFED4
`define ERR_DEV_LO 16'hFE71

`endif

//--- design/status_pkg.sv
/*
 Types of the status block: command codes, sequencer states, state records.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package status_pkg;
	// Commands issued by the parser
	typedef enum logic [3:0] {
		CMD_NONE,
		CMD_READ_EVENT_LATCH,
		CMD_WRITE_EVENT_MASK,
		CMD_READ_EVENT_MASK,
		CMD_READ_OPER_COND,
		CMD_READ_OPER_EVENT,
		CMD_WRITE_OPER_MASK,
		CMD_READ_OPER_MASK,
		CMD_READ_QUES_COND,
		CMD_READ_QUES_EVENT,
		CMD_WRITE_QUES_MASK,
		CMD_READ_QUES_MASK
	} cmd_t;

	// Operation-complete sequencer
	typedef enum logic {
		OPC_IDLE,
		OPC_WAIT
	} opc_state_t;

	// Main block state
	typedef struct packed {
		logic [7:0] eventLatch;
		logic [7:0] eventMask;
		opc_state_t opcState;
		logic localPrev;
		logic respValid;
		logic [15:0] respData;
		logic [7:0] statusByte;
		logic errPush;
		logic [15:0] errCode;
	} top_state_t;

	// Sixteen-bit condition/event/enable register state
	typedef struct packed {
		logic [15:0] condView;
		logic [15:0] eventView;
		logic [15:0] maskView;
		logic summary;
	} sub_state_t;
endpackage : status_pkg
`default_nettype wire

//--- design/status_sub_if.sv
/*
 Link between the main status block and one sixteen-bit status register.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface status_sub_if;
	logic [15:0] cond;
	logic readEvent;
	logic maskWrite;
	logic [15:0] maskData;
	logic [15:0] condView;
	logic [15:0] eventView;
	logic [15:0] maskView;
	logic summary;

	modport ctrl (
		output cond, readEvent, maskWrite, maskData,
		input condView, eventView, maskView, summary
	);
	modport regs (
		input cond, readEvent, maskWrite, maskData,
		output condView, eventView, maskView, summary
	);
endinterface : status_sub_if
`default_nettype wire

//--- design/status_sub_reg.sv
/*
 One sixteen-bit status register: condition view, edge-latched event view
 cleared by its read, enable mask and summary bit.
 Assumes the controlling block drives cond from logic on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module status_sub_reg #(
	parameter logic [15:0] USED_MASK = 16'h0000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register link
	status_sub_if.regs regPort
);
	status_pkg::sub_state_t stateReg;
	status_pkg::sub_state_t stateNext;
	logic [15:0] riseBits;

	// Rising edges of used condition bits
	assign riseBits = regPort.cond & ~stateReg.condView & USED_MASK;

	// Next state; a new edge wins over the clearing read
	always_comb begin
		stateNext = stateReg;
		stateNext.condView = regPort.cond & USED_MASK;
		stateNext.eventView = ((regPort.readEvent ? 16'h0000 : stateReg.eventView) | riseBits)
			& USED_MASK;
		if (regPort.maskWrite) begin
			stateNext.maskView = regPort.maskData & USED_MASK;
		end
		stateNext.summary = |(stateNext.eventView & stateNext.maskView);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stateReg <= '0;
		end else begin
			stateReg <= stateNext;
		end
	end

	assign regPort.condView = stateReg.condView;
	assign regPort.eventView = stateReg.eventView;
	assign regPort.maskView = stateReg.maskView;
	assign regPort.summary = stateReg.summary;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	event_catch_a: assert property (|riseBits |=> (stateReg.eventView & $past(riseBits))
		== $past(riseBits)) else $error("condition edge not latched");
	read_clear_a: assert property (regPort.readEvent && riseBits == 16'h0000
		|=> stateReg.eventView == 16'h0000) else $error("event view not cleared");
	unused_zero_a: assert property (((stateReg.eventView | stateReg.condView
		| stateReg.maskView) & ~USED_MASK) == 16'h0000) else $error("unused bit set");
endmodule : status_sub_reg
`default_nettype wire

//--- design/event_and_operation_status_regs.sv
/*
 Status reporting core: standard event latch with its enable mask, the
 operation and questionable registers, summary bits of the status byte and
 error-queue entries.
 Assumes every input comes from logic on clk (the command parser and the
 acquisition control), so none is synchronised here.
*/
// Operation
// - Enabled event bit rising sets event summary
// - Event mask written and read back unchanged
// - Operation complete set once commands finish
// - Query protocol fault sets event bit 2
// - Device fault sets bit 3, queues error; no entry when an execution or command fault comes in the same cycle
// - Execution fault sets bit 4, queues error; no entry when a command fault comes in the same cycle
// - Command fault sets bit 5, queues error
// - Switch to local control sets bit 6
// - Power-on sets event bit 7
// - Operation register has condition and event views
// - Condition bits 0,1: calibration, self-test running
// - Condition bits 2,3: auto setup, trigger wait
// - Bit 15 reads zero; bits 4-14 unused
// - Questionable bit 3: any channel overload
// - Questionable bit 4: temperature condition
// - Questionable bit 5: converter clipping
// - Questionable bit 8: calibration data missing
// - Questionable bit 9: measurement limit violated
// - Questionable bit 12: mask test violated
// - Event summary sits at status byte bit 5
// - Summaries feed the next higher register
// - Event latch 8 bits, others 16 bits
// - Questionable summary at status byte bit 3
`timescale 1ns/10ps
`default_nettype none
`include "status_defines.svh"
module event_and_operation_status_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Command port from the parser
	input wire logic reqValid,
	input wire status_pkg::cmd_t reqCmd,
	input wire logic [15:0] reqData,
	output logic respValid,
	output logic [15:0] respData,
	// Standard event sources
	input wire logic opcReceived,
	input wire logic commandsPending,
	input wire logic readWithoutQuery,
	input wire logic unreadDataOverwritten,
	input wire logic deviceFault,
	input wire logic executionFault,
	input wire logic commandFault,
	input wire logic [15:0] faultCode,
	input wire logic localControl,
	// Operation conditions
	input wire logic selfCalRunning,
	input wire logic selfTestRunning,
	input wire logic automaticSetupActive,
	input wire logic awaitingTrigger,
	// Questionable conditions
	input wire logic [3:0] overloadPerChannel,
	input wire logic [1:0] temperatureFlags,
	input wire logic [7:0] clippingPerEdge,
	input wire logic calibrationDataMissing,
	input wire logic [7:0] limitViolations,
	input wire logic maskViolation,
	// Status byte and error queue
	output logic [7:0] statusByte,
	output logic errPush,
	output logic [15:0] errCode
);
	localparam status_pkg::top_state_t TOP_RESET = '{
		eventLatch: `EVT_RESET_VALUE,
		eventMask: `EVT_MASK_RESET,
		opcState: status_pkg::OPC_IDLE,
		localPrev: 1'b0,
		respValid: 1'b0,
		respData: 16'h0000,
		statusByte: 8'h00,
		errPush: 1'b0,
		errCode: 16'h0000
	};

	status_pkg::top_state_t stateReg;
	status_pkg::top_state_t stateNext;
	status_sub_if operIf ();
	status_sub_if quesIf ();
	logic [15:0] operCond;
	logic [15:0] quesCond;
	logic [7:0] evtSet;
	logic opcDone;
	logic readLatch;
	logic channelOverloadSummary;
	logic converterClippingSummary;
	logic [7:0] reqLow;

	// True when a code lies inside a signed window
	function automatic logic inRange(input logic [15:0] code, input logic [15:0] lo,
		input logic [15:0] hi);
		return ($signed(code) >= $signed(lo)) && ($signed(code) <= $signed(hi));
	endfunction : inRange

	assign reqLow = reqData[7:0];
	assign readLatch = reqValid && reqCmd == status_pkg::CMD_READ_EVENT_LATCH;

	// Operation conditions; bits 4 to 15 stay zero
	always_comb begin
		operCond = 16'h0000;
		operCond[`OPER_CAL_BIT] = selfCalRunning;
		operCond[`OPER_TEST_BIT] = selfTestRunning;
		operCond[`OPER_SETUP_BIT] = automaticSetupActive;
		operCond[`OPER_TRIG_BIT] = awaitingTrigger;
	end

	// Questionable summaries of the per-channel sources
	assign channelOverloadSummary = |overloadPerChannel;
	assign converterClippingSummary = |clippingPerEdge;

	always_comb begin
		quesCond = 16'h0000;
		quesCond[`QUES_OVERLOAD_BIT] = channelOverloadSummary;
		quesCond[`QUES_TEMP_BIT] = |temperatureFlags;
		quesCond[`QUES_CLIP_BIT] = converterClippingSummary;
		quesCond[`QUES_NOCAL_BIT] = calibrationDataMissing;
		quesCond[`QUES_LIMIT_BIT] = |limitViolations;
		quesCond[`QUES_MASKTEST_BIT] = maskViolation;
	end

	// Drive the two register links
	assign operIf.cond = operCond;
	assign operIf.readEvent = reqValid && reqCmd == status_pkg::CMD_READ_OPER_EVENT;
	assign operIf.maskWrite = reqValid && reqCmd == status_pkg::CMD_WRITE_OPER_MASK;
	assign operIf.maskData = reqData;
	assign quesIf.cond = quesCond;
	assign quesIf.readEvent = reqValid && reqCmd == status_pkg::CMD_READ_QUES_EVENT;
	assign quesIf.maskWrite = reqValid && reqCmd == status_pkg::CMD_WRITE_QUES_MASK;
	assign quesIf.maskData = reqData;

	status_sub_reg #(
		.USED_MASK(`OPER_USED_MASK)
	) operReg (
		.clk(clk),
		.sys_rst(sys_rst),
		.regPort(operIf)
	);

	status_sub_reg #(
		.USED_MASK(`QUES_USED_MASK)
	) quesReg (
		.clk(clk),
		.sys_rst(sys_rst),
		.regPort(quesIf)
	);

	// Event sources; several may fire in one cycle and all are latched
	always_comb begin
		evtSet = 8'h00;
		evtSet[`EVT_OPC_BIT] = opcDone;
		evtSet[`EVT_QUERY_BIT] = readWithoutQuery || unreadDataOverwritten;
		evtSet[`EVT_DEVICE_BIT] = deviceFault;
		evtSet[`EVT_EXEC_BIT] = executionFault;
		evtSet[`EVT_CMD_BIT] = commandFault;
		evtSet[`EVT_USER_BIT] = localControl && !stateReg.localPrev;
	end

	// Next state of the main block
	always_comb begin
		stateNext = stateReg;
		opcDone = 1'b0;
		stateNext.respValid = 1'b0;
		stateNext.errPush = 1'b0;
		stateNext.localPrev = localControl;

		// Operation complete waits until nothing is pending
		case (stateReg.opcState)
			status_pkg::OPC_IDLE: begin
				if (opcReceived) begin
					if (commandsPending) begin
						stateNext.opcState = status_pkg::OPC_WAIT;
					end else begin
						opcDone = 1'b1;
					end
				end
			end
			status_pkg::OPC_WAIT: begin
				if (!commandsPending) begin
					opcDone = 1'b1;
					stateNext.opcState = status_pkg::OPC_IDLE;
				end
			end
			default: begin
				stateNext.opcState = status_pkg::OPC_IDLE;
			end
		endcase

		// Reading the latch clears it, but a new event in that cycle survives
		stateNext.eventLatch = ((readLatch ? 8'h00 : stateReg.eventLatch) | evtSet)
			& `EVT_USED_MASK;

		// Mask stores all eight bits so it reads back as written
		if (reqValid && reqCmd == status_pkg::CMD_WRITE_EVENT_MASK) begin
			stateNext.eventMask = reqLow;
		end

		// Query answers, one cycle after the request
		if (reqValid) begin
			stateNext.respValid = 1'b1;
			case (reqCmd)
				status_pkg::CMD_READ_EVENT_LATCH: begin
					stateNext.respData = {8'h00, stateReg.eventLatch};
				end
				status_pkg::CMD_READ_EVENT_MASK: begin
					stateNext.respData = {8'h00, stateReg.eventMask};
				end
				status_pkg::CMD_READ_OPER_COND: begin
					stateNext.respData = operIf.condView;
				end
				status_pkg::CMD_READ_OPER_EVENT: begin
					stateNext.respData = operIf.eventView;
				end
				status_pkg::CMD_READ_OPER_MASK: begin
					stateNext.respData = operIf.maskView;
				end
				status_pkg::CMD_READ_QUES_COND: begin
					stateNext.respData = quesIf.condView;
				end
				status_pkg::CMD_READ_QUES_EVENT: begin
					stateNext.respData = quesIf.eventView;
				end
				status_pkg::CMD_READ_QUES_MASK: begin
					stateNext.respData = quesIf.maskView;
				end
				default: begin
					stateNext.respValid = 1'b0; // Writes and idle give no answer
				end
			endcase
		end

		// Only one queue entry per cycle; the grossest fault is reported
		if (commandFault) begin
			stateNext.errPush = 1'b1;
			stateNext.errCode = inRange(faultCode, `ERR_CMD_LO, `ERR_CMD_HI) ?
				faultCode : `ERR_CMD_HI;
		end else if (executionFault) begin
			stateNext.errPush = 1'b1;
			stateNext.errCode = inRange(faultCode, `ERR_EXEC_LO, `ERR_EXEC_HI) ?
				faultCode : `ERR_EXEC_HI;
		end else if (deviceFault) begin
			stateNext.errPush = 1'b1;
			stateNext.errCode = (inRange(faultCode, `ERR_DEV_LO, `ERR_DEV_HI)
				|| $signed(faultCode) > $signed(16'h0000)) ? faultCode : `ERR_DEV_HI;
		end

		// Status byte summaries; other bits belong to logic outside
		stateNext.statusByte = 8'h00;
		stateNext.statusByte[`STB_ESB_BIT] =
			|(stateNext.eventLatch & stateNext.eventMask);
		stateNext.statusByte[`STB_QUES_BIT] = quesIf.summary;
		stateNext.statusByte[`STB_OPER_BIT] = operIf.summary;
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stateReg <= TOP_RESET;
		end else begin
			stateReg <= stateNext;
		end
	end

	// Outputs straight from the state register
	assign respValid = stateReg.respValid;
	assign respData = stateReg.respData;
	assign statusByte = stateReg.statusByte;
	assign errPush = stateReg.errPush;
	assign errCode = stateReg.errCode;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Steps of the mask round trip and of the completion handshake
	sequence maskWriteSeq;
		reqValid && reqCmd == status_pkg::CMD_WRITE_EVENT_MASK;
	endsequence

	sequence maskReadSeq;
		reqValid && reqCmd == status_pkg::CMD_READ_EVENT_MASK;
	endsequence

	sequence opcBlockedSeq;
		stateReg.opcState == status_pkg::OPC_IDLE && opcReceived && commandsPending;
	endsequence

	sequence opcFreeSeq;
		stateReg.opcState == status_pkg::OPC_IDLE && opcReceived && !commandsPending;
	endsequence

	// Event latch, its mask and the status byte
	esb_summary_a: assert property (stateReg.statusByte[`STB_ESB_BIT]
		== |(stateReg.eventLatch & stateReg.eventMask))
		else $error("event summary out of step");
	stb_unused_a: assert property ((statusByte & 8'h57) == 8'h00)
		else $error("foreign status byte bit set");
	mask_readback_a: assert property (maskWriteSeq ##1 maskReadSeq |=> respValid
		&& respData == {8'h00, $past(reqLow, 2)})
		else $error("event mask read back wrong");
	latch_answer_a: assert property (readLatch |=> respValid
		&& respData == {8'h00, $past(stateReg.eventLatch)})
		else $error("event latch answer wrong");
	latch_unused_a: assert property (stateReg.eventLatch[1] == 1'b0)
		else $error("unused event bit set");

	// Completion handshake; an early set would hide a still running command
	opc_rise_a: assert property ($rose(stateReg.eventLatch[`EVT_OPC_BIT])
		|-> $past(!commandsPending)) else $error("completion set too early");
	opc_wait_a: assert property (opcBlockedSeq ##1 !commandsPending
		|=> stateReg.eventLatch[`EVT_OPC_BIT]) else $error("completion never set");
	opc_free_a: assert property (opcFreeSeq |=> stateReg.eventLatch[`EVT_OPC_BIT])
		else $error("immediate completion lost");

	// Event sources and error-queue entries
	query_err_a: assert property ((readWithoutQuery || unreadDataOverwritten)
		|=> stateReg.eventLatch[`EVT_QUERY_BIT]) else $error("query fault lost");
	dev_err_a: assert property (deviceFault && !executionFault && !commandFault
		|=> stateReg.eventLatch[`EVT_DEVICE_BIT] && errPush
		&& ($signed(errCode) > $signed(16'h0000)
		|| ($signed(errCode) <= $signed(`ERR_DEV_HI)
		&& $signed(errCode) >= $signed(`ERR_DEV_LO))))
		else $error("device fault entry wrong");
	exec_err_a: assert property (executionFault && !commandFault
		|=> stateReg.eventLatch[`EVT_EXEC_BIT] && errPush
		&& $signed(errCode) <= $signed(`ERR_EXEC_HI)
		&& $signed(errCode) >= $signed(`ERR_EXEC_LO))
		else $error("execution fault entry wrong");
	cmd_err_a: assert property (commandFault
		|=> stateReg.eventLatch[`EVT_CMD_BIT] && errPush
		&& $signed(errCode) <= $signed(`ERR_CMD_HI)
		&& $signed(errCode) >= $signed(`ERR_CMD_LO))
		else $error("command fault entry wrong");
	user_req_a: assert property ($rose(localControl)
		|=> stateReg.eventLatch[`EVT_USER_BIT]) else $error("local switch lost");

	// Summaries of the two sixteen-bit registers, one cycle behind the sub-register
	ques_summary_a: assert property (statusByte[`STB_QUES_BIT]
		== $past(quesIf.summary)) else $error("questionable summary lost");
	oper_summary_a: assert property (statusByte[`STB_OPER_BIT]
		== $past(operIf.summary)) else $error("operation summary lost");
	oper_cond_a: assert property (reqValid && reqCmd == status_pkg::CMD_READ_OPER_COND
		|=> respValid && respData[`OPER_TRIG_BIT] == $past(operIf.condView[`OPER_TRIG_BIT]))
		else $error("operation condition read wrong");
endmodule : event_and_operation_status_regs
`default_nettype wire

//--- testbench/status_host_model.sv
/*
 Partner model: the remote controller's command issuer for the status core.
 Assumes the bench calls its tasks at a falling clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module status_host_model (
	// Clock
	input wire logic clk,
	// Command port towards the core
	output logic reqValid,
	output status_pkg::cmd_t reqCmd,
	output logic [15:0] reqData
);
	// Idle request at time zero
	initial begin
		reqValid = 1'b0;
		reqCmd = status_pkg::CMD_NONE;
		reqData = 16'hA5A5;
	end

	// One request held over its sampling edge; chained calls give back-to-back commands
	task automatic issue(input status_pkg::cmd_t c, input logic [15:0] d);
		reqValid <= 1'b1;
		reqCmd <= c;
		reqData <= d;
		@(negedge clk);
	endtask : issue

	// Release the port; the data lines then show no stale value
	task automatic release_port(input int gap);
		reqValid <= 1'b0;
		reqCmd <= status_pkg::CMD_NONE;
		reqData <= ~reqData;
		repeat (gap + 1) @(negedge clk);
	endtask : release_port
endmodule : status_host_model
`default_nettype wire

//--- testbench/event_and_operation_status_regs_test.sv
/*
 Self-checking bench of the status core: event latch, masks, faults,
 operation and questionable registers and the status byte.
 Assumes the controller model drives the command port; answers are checked from queues.
*/
`timescale 1ns/10ps
`default_nettype none
module event_and_operation_status_regs_test;
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	logic reqValid;
	status_pkg::cmd_t reqCmd;
	logic [15:0] reqData;
	logic respValid;
	logic [15:0] respData;
	logic opcReceived, commandsPending;
	logic [5:0] evtSrc;
	logic [15:0] faultCode;
	logic [3:0] operCond;
	logic [23:0] quesCond;
	logic [7:0] statusByte;
	logic errPush;
	logic [15:0] errCode;
	logic [15:0] expResp[$];
	logic [15:0] expErr[$];
	int numErrors = 0;
	int totalChecks = 0;
	int seed = 32'hF8C69117;

	// Clock, 4 ns period
	always #2 clk = ~clk;

	// Device under test
	event_and_operation_status_regs i_dut (
		.clk(clk), .sys_rst(sysRst),
		.reqValid(reqValid), .reqCmd(reqCmd), .reqData(reqData),
		.respValid(respValid), .respData(respData),
		.opcReceived(opcReceived), .commandsPending(commandsPending),
		.readWithoutQuery(evtSrc[0]), .unreadDataOverwritten(evtSrc[1]),
		.deviceFault(evtSrc[2]), .executionFault(evtSrc[3]),
		.commandFault(evtSrc[4]), .faultCode(faultCode), .localControl(evtSrc[5]),
		.selfCalRunning(operCond[0]), .selfTestRunning(operCond[1]),
		.automaticSetupActive(operCond[2]), .awaitingTrigger(operCond[3]),
		.overloadPerChannel(quesCond[3:0]), .temperatureFlags(quesCond[5:4]),
		.clippingPerEdge(quesCond[13:6]), .calibrationDataMissing(quesCond[14]),
		.limitViolations(quesCond[22:15]), .maskViolation(quesCond[23]),
		.statusByte(statusByte), .errPush(errPush), .errCode(errCode)
	);

	// Controller model on the command port
	status_host_model i_host (
		.clk(clk), .reqValid(reqValid), .reqCmd(reqCmd), .reqData(reqData)
	);

	// Single comparison point
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic reportAndStop;
		$display("Checks made %0d, mismatches %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : reportAndStop

	// Read with expected answer noted first; write data is random for reads
	task automatic rd(input status_pkg::cmd_t c, input logic [15:0] exp);
		expResp.push_back(exp);
		i_host.issue(c, 16'($random(seed)));
	endtask : rd

	// Answer and error-queue watcher; oldest note is compared on each result
	always @(negedge clk) begin
		if (!sysRst && respValid === 1'b1) begin
			if (expResp.size() == 0) check("unexpected respValid", 16'h0001, 16'h0000);
			else check("respData", respData, expResp.pop_front());
		end
		if (!sysRst && errPush === 1'b1) begin
			if (expErr.size() == 0) check("unexpected errPush", 16'h0001, 16'h0000);
			else check("errCode", errCode, expErr.pop_front());
		end
	end

	// Watchdog, far beyond the expected run length
	initial begin
		#40000;
		numErrors++;
		reportAndStop();
	end

	// Main sequence
	initial begin
		logic [31:0] r;
		logic [15:0] code;
		int lo[6] = '{0, 4, 6, 14, 15, 23};
		int w[6] = '{4, 2, 8, 1, 8, 1};
		int qb[6] = '{3, 4, 5, 8, 9, 12};
		{opcReceived, commandsPending} = 2'b00;
		evtSrc = 6'h00;
		faultCode = 16'h0000;
		operCond = 4'h0;
		quesCond = 24'h000000;
		repeat (4) @(posedge clk);
		@(negedge clk);
		sysRst = 1'b0;
		// Power-on event, then destructive read
		check("statusByte", {8'h00, statusByte}, 16'h0000);
		rd(status_pkg::CMD_READ_EVENT_LATCH, 16'h0080);
		rd(status_pkg::CMD_READ_EVENT_LATCH, 16'h0000);
		rd(status_pkg::CMD_READ_OPER_EVENT, 16'h0000);
		// Masks, back to back, unused bits dropped
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			i_host.issue(status_pkg::CMD_WRITE_EVENT_MASK, r[15:0]);
			rd(status_pkg::CMD_READ_EVENT_MASK, {8'h00, r[7:0]});
		end
		i_host.issue(status_pkg::CMD_WRITE_OPER_MASK, 16'hFFFF);
		rd(status_pkg::CMD_READ_OPER_MASK, 16'h000F);
		i_host.issue(status_pkg::CMD_WRITE_QUES_MASK, 16'hFFFF);
		rd(status_pkg::CMD_READ_QUES_MASK, 16'h1338);
		i_host.issue(status_pkg::CMD_WRITE_EVENT_MASK, 16'h0020);
		i_host.release_port(0);
		$display("Test masks done");
		// Fault and event sources; only the command bit is enabled
		for (int k = 0; k < 6; k++) begin
			r = $random(seed);
			code = (k == 2) ? {1'b0, r[14:1], 1'b1} : (k == 3) ? 16'hFF06 : 16'hFF38;
			if (k >= 2 && k <= 4) expErr.push_back((k == 4) ? 16'hFF9C : code);
			faultCode <= code;
			evtSrc <= 6'h01 << k;
			@(negedge clk);
			evtSrc <= 6'h00;
			check("event summary", {15'h0000, statusByte[5]}, {15'h0000, k == 4});
			rd(status_pkg::CMD_READ_EVENT_LATCH, 16'h0001 << ((k < 2) ? 2 : k + 1));
			i_host.release_port(0);
			check("event summary cleared", {15'h0000, statusByte[5]}, 16'h0000);
		end
		// Device and execution fault together: both bits, one entry from the execution window
		expErr.push_back(16'hFF06);
		faultCode <= 16'hFF06;
		evtSrc <= 6'h0C;
		@(negedge clk);
		evtSrc <= 6'h00;
		rd(status_pkg::CMD_READ_EVENT_LATCH, 16'h0018);
		i_host.release_port(0);
		$display("Test events done");
		// Operation complete, held back while commands are pending
		commandsPending <= 1'b1;
		opcReceived <= 1'b1;
		@(negedge clk);
		opcReceived <= 1'b0;
		repeat (3) @(negedge clk);
		rd(status_pkg::CMD_READ_EVENT_LATCH, 16'h0000);
		i_host.release_port(0);
		commandsPending <= 1'b0;
		repeat (3) @(negedge clk);
		rd(status_pkg::CMD_READ_EVENT_LATCH, 16'h0001);
		i_host.release_port(0);
		// One pending cycle, then a completion with nothing pending at all
		commandsPending <= 1'b1;
		opcReceived <= 1'b1;
		@(negedge clk);
		{opcReceived, commandsPending} <= 2'b00;
		@(negedge clk);
		rd(status_pkg::CMD_READ_EVENT_LATCH, 16'h0001);
		opcReceived <= 1'b1;
		i_host.release_port(0);
		opcReceived <= 1'b0;
		rd(status_pkg::CMD_READ_EVENT_LATCH, 16'h0001);
		i_host.release_port(0);
		$display("Test completion done");
		// Operation conditions, event views and summary at bit 7
		for (int i = 0; i < 4; i++) begin
			operCond <= 4'h1 << i;
			@(negedge clk);
			rd(status_pkg::CMD_READ_OPER_COND, 16'h0001 << i);
			check("oper summary", {15'h0000, statusByte[7]}, 16'h0001);
			rd(status_pkg::CMD_READ_OPER_EVENT, 16'h0001 << i);
			rd(status_pkg::CMD_READ_OPER_EVENT, 16'h0000);
			i_host.release_port(0);
			operCond <= 4'h0;
			@(negedge clk);
		end
		$display("Test operation done");
		// Questionable sources, random member of each group
		for (int k = 0; k < 6; k++) begin
			r = $random(seed);
			quesCond <= 24'h000001 << (lo[k] + int'(r % w[k]));
			@(negedge clk);
			rd(status_pkg::CMD_READ_QUES_COND, 16'h0001 << qb[k]);
			check("ques summary", {15'h0000, statusByte[3]}, 16'h0001);
			rd(status_pkg::CMD_READ_QUES_EVENT, 16'h0001 << qb[k]);
			rd(status_pkg::CMD_READ_QUES_EVENT, 16'h0000);
			i_host.release_port(0);
			quesCond <= 24'h000000;
			@(negedge clk);
		end
		$display("Test questionable done");
		repeat (4) @(negedge clk);
		check("answers outstanding", 16'(expResp.size()), 16'h0000);
		check("errors outstanding", 16'(expErr.size()), 16'h0000);
		reportAndStop();
	end
endmodule : event_and_operation_status_regs_test
`default_nettype wire
